/* rtl/ctaf_map.svh */
`ifndef CTAF_MAP_SVH
`define CTAF_MAP_SVH

// Register byte offsets on the register bus.
`define CTAF_OFS_ABORT_DONE 8'h00
`define CTAF_OFS_PICK       8'h04
`define CTAF_OFS_FILTER     8'h08
`define CTAF_OFS_TX_FLAG    8'h0C
`define CTAF_OFS_ABORT_REQ  8'h10
`define CTAF_OFS_IRQ_STAT   8'h14
`define CTAF_OFS_IRQ_EN     8'h18
`define CTAF_OFS_IRQ_CLR    8'h1C

// Field positions.
`define CTAF_MODE_LSB 4
`define CTAF_HIT_LSB  0
`define CTAF_RX_IRQ_BIT 3

// Reset values.
`define CTAF_RST_ABORT_DONE 3'h0
`define CTAF_RST_PICK       3'h0
`define CTAF_RST_TX_EMPTY   3'h7
`define CTAF_RST_ABORT_REQ  3'h0
`define CTAF_RST_MODE       2'h0
`define CTAF_RST_HIT        3'h0
`define CTAF_RST_IRQ        4'h0

// Bus answers.
`define CTAF_RESP_OKAY   2'h0
`define CTAF_RESP_SLVERR 2'h2

`endif

/* rtl/ctaf_pkg.sv */
`default_nettype none
package ctaf_pkg;
  typedef enum logic [1:0] {
    FILT_TWO_32,
    FILT_FOUR_16,
    FILT_EIGHT_8,
    FILT_CLOSED
  } ctaf_filt_e;
  typedef logic [2:0] ctaf_buf_t;
  typedef logic [3:0] ctaf_irq_t;
endpackage
`default_nettype wire

/* rtl/ctaf_lowbit.sv */
`timescale 1ns/10ps
`default_nettype none
module ctaf_lowbit (
  // Raw selection
  input  wire logic [2:0] req,
  // Lowest set bit only
  output logic      [2:0] low
);
  logic [3:0] seen;

  assign seen[0] = 1'b0;

  genvar i;
  for (i = 0; i < 3; i = i + 1) begin : g_bit
    assign low[i]      = req[i] & ~seen[i];
    assign seen[i + 1] = seen[i] | req[i];
  end
endmodule
`default_nettype wire

/* rtl/ctaf_axil.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ctaf_map.svh"
module ctaf_axil (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  logic aw_full;
  logic w_full;

  assign wr_en   = aw_full & w_full & ~bvalid;
  assign rd_addr = araddr;

  // Address and data are held separately so either may arrive first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `CTAF_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        wr_addr <= awaddr;
        aw_full <= 1'b1;
        awready <= 1'b0;
      end else if (!aw_full && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        w_full  <= 1'b1;
        wready  <= 1'b0;
      end else if (!w_full && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_en) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_err ? `CTAF_RESP_SLVERR : `CTAF_RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `CTAF_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_data;
      rresp   <= rd_err ? `CTAF_RESP_SLVERR : `CTAF_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* rtl/ctaf_top.sv */
// How it works
// - Abort acknowledge held reset in init mode.
// - Abort acknowledge flags are read-only to software.
// - Flag sets when abort request aborted message.
// - Clearing empty flag clears abort acknowledge.
// - Buffer select reset in init, writable only in run mode.
// - Lowest set select bit maps the window.
// - Select reads back lowest set bit only.
// - Window blocked while selected buffer scheduled.
// - No buffer selected means no window access.
// - Mode writable only in init; hit read-only.
// - Mode decodes 2x32, 4x16, 8x8, closed.
// - Closed filter never reloads foreground buffer.
// - Hit field gives matching filter number 0-7.
// - Hit updates when foreground buffer is loaded.
// - Empty flag sets on send or granted abort.
// - Abort granted only if idle or failed.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ctaf_map.svh"
module ctaf_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Register bus, write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Register bus, write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Register bus, write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Register bus, read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Register bus, read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Controller mode
  input  wire logic        init_request,
  input  wire logic        init_acknowledge,
  // Transmit engine
  input  wire logic [2:0]  tx_sent,
  input  wire logic [2:0]  tx_active,
  output logic [2:0]       tx_buffer_empty_flags,
  output logic [2:0]       abort_request_bits,
  // Transmit buffer window
  output logic [2:0]       tx_window_sel,
  output logic             tx_window_open,
  // Receive side
  input  wire logic        rx_shift,
  input  wire logic [2:0]  rx_hit_in,
  output logic [1:0]       filter_mode,
  output logic [7:0]       filter_enables,
  output logic             rx_fg_load,
  // Interrupt
  output logic             irq
);
  // Reset release.
  // The release is synchronised so every flop leaves reset on one edge.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Register bus slave.
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;

  ctaf_axil u_axil (
    .clk     (sys_clk),
    .rst_n   (rst_n),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // State.
  ctaf_pkg::ctaf_buf_t  abort_done_flags;
  ctaf_pkg::ctaf_buf_t  pick;
  ctaf_pkg::ctaf_buf_t  filter_match_field;
  ctaf_pkg::ctaf_irq_t  irq_stat;
  ctaf_pkg::ctaf_irq_t  irq_en;
  ctaf_pkg::ctaf_filt_e mode;

  // Mode decode.
  logic init_mode;
  logic run_mode;

  assign init_mode = init_request & init_acknowledge;
  assign run_mode  = ~init_request & ~init_acknowledge;

  // Write decode; only byte lane 0 holds implemented bits.
  logic wr_lo;
  logic wr_mapped;
  logic wr_pick;
  logic wr_filter;
  logic wr_txflag;
  logic wr_abreq;
  logic wr_irq_en;
  logic wr_irq_clr;

  assign wr_lo      = wr_en & wr_strb[0];
  assign wr_pick    = wr_lo & (wr_addr == `CTAF_OFS_PICK);
  assign wr_filter  = wr_lo & (wr_addr == `CTAF_OFS_FILTER);
  assign wr_txflag  = wr_lo & (wr_addr == `CTAF_OFS_TX_FLAG);
  assign wr_abreq   = wr_lo & (wr_addr == `CTAF_OFS_ABORT_REQ);
  assign wr_irq_en  = wr_lo & (wr_addr == `CTAF_OFS_IRQ_EN);
  assign wr_irq_clr = wr_lo & (wr_addr == `CTAF_OFS_IRQ_CLR);
  assign wr_mapped  = (wr_addr == `CTAF_OFS_ABORT_DONE)
                    | (wr_addr == `CTAF_OFS_PICK)
                    | (wr_addr == `CTAF_OFS_FILTER)
                    | (wr_addr == `CTAF_OFS_TX_FLAG)
                    | (wr_addr == `CTAF_OFS_ABORT_REQ)
                    | (wr_addr == `CTAF_OFS_IRQ_STAT)
                    | (wr_addr == `CTAF_OFS_IRQ_EN)
                    | (wr_addr == `CTAF_OFS_IRQ_CLR);
  // A write to a hole in the map answers with an error so it is not lost.
  assign wr_err     = ~wr_mapped;

  // Transmit bookkeeping.
  logic [2:0] cpu_clr_txe;
  logic [2:0] cpu_abreq;
  logic [2:0] abort_grant;
  logic [2:0] txe_set;
  logic [2:0] next_txe;
  logic [2:0] next_abort_done_flags;
  logic [2:0] next_abreq;

  assign cpu_clr_txe = {3{wr_txflag & run_mode}} & wr_data[2:0];
  assign cpu_abreq   = {3{wr_abreq & run_mode}} & wr_data[2:0];
  // A buffer already on the wire keeps going; a success beats the abort.
  assign abort_grant = abort_request_bits & ~tx_buffer_empty_flags
                     & ~tx_active & ~tx_sent;
  assign txe_set     = tx_sent | abort_grant;
  // The engine's set wins over a software clear in the same cycle.
  assign next_txe    = (tx_buffer_empty_flags & ~cpu_clr_txe) | txe_set;
  assign next_abort_done_flags  = (abort_done_flags & ~cpu_clr_txe)
                     | abort_grant;
  // A request on an empty buffer has nothing to abort and is dropped.
  assign next_abreq  = (abort_request_bits | cpu_abreq)
                     & ~tx_buffer_empty_flags & ~txe_set;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buffer_empty_flags <= `CTAF_RST_TX_EMPTY;
      abort_done_flags      <= `CTAF_RST_ABORT_DONE;
      abort_request_bits    <= `CTAF_RST_ABORT_REQ;
    end else if (init_mode) begin
      tx_buffer_empty_flags <= `CTAF_RST_TX_EMPTY;
      abort_done_flags      <= `CTAF_RST_ABORT_DONE;
      abort_request_bits    <= `CTAF_RST_ABORT_REQ;
    end else begin
      tx_buffer_empty_flags <= next_txe;
      abort_done_flags      <= next_abort_done_flags;
      abort_request_bits    <= next_abreq;
    end
  end

  // Buffer select; software is expected to write back the flag value.
  logic [2:0] pick_low;
  logic [2:0] next_pick;
  logic       next_window_open;
  logic       wr_pick_ok;
  logic [2:0] pick_free;

  ctaf_lowbit u_lowbit (
    .req (pick),
    .low (pick_low)
  );

  assign wr_pick_ok = wr_pick & run_mode;
  assign next_pick  = wr_pick_ok ? wr_data[2:0] : pick;
  // A scheduled buffer stays locked so its frame cannot change mid-send.
  assign pick_free        = pick_low & tx_buffer_empty_flags;
  assign next_window_open = |pick_free;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pick           <= `CTAF_RST_PICK;
      tx_window_sel  <= `CTAF_RST_PICK;
      tx_window_open <= 1'b0;
    end else begin
      pick           <= init_mode ? `CTAF_RST_PICK : next_pick;
      tx_window_sel  <= pick_low;
      tx_window_open <= next_window_open;
    end
  end

  // Acceptance filter control.
  logic       rx_accept;
  logic       wr_mode;
  logic [7:0] next_enables;

  // A closed filter drops the frame before it can touch the hit field.
  assign rx_accept = rx_shift & (mode != ctaf_pkg::FILT_CLOSED);
  assign wr_mode   = wr_filter & init_mode;

  always_comb begin
    case (mode)
      ctaf_pkg::FILT_TWO_32:  next_enables = 8'h03;
      ctaf_pkg::FILT_FOUR_16: next_enables = 8'h0F;
      ctaf_pkg::FILT_EIGHT_8: next_enables = 8'hFF;
      default:                next_enables = 8'h00;
    endcase
  end

  // Init mode leaves the filter set-up alone so it survives a restart.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= ctaf_pkg::ctaf_filt_e'(`CTAF_RST_MODE);
    end else if (wr_mode) begin
      mode <= ctaf_pkg::ctaf_filt_e'(wr_data[`CTAF_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_match_field <= `CTAF_RST_HIT;
      rx_fg_load         <= 1'b0;
      filter_mode        <= `CTAF_RST_MODE;
      filter_enables     <= 8'h00;
    end else begin
      if (rx_accept) begin
        filter_match_field <= rx_hit_in;
      end
      rx_fg_load     <= rx_accept;
      filter_mode    <= mode;
      filter_enables <= next_enables;
    end
  end

  // Interrupt status; an event in the clearing cycle stays set.
  logic [3:0] irq_event;
  logic [3:0] irq_clr;
  logic [3:0] next_stat;
  logic [3:0] next_en;
  logic       next_irq;

  assign irq_event = {rx_accept, txe_set};
  assign irq_clr   = {4{wr_irq_clr}} & wr_data[3:0];
  assign next_stat = (irq_stat & ~irq_clr) | irq_event;
  assign next_en   = wr_irq_en ? wr_data[3:0] : irq_en;
  // The pin trails the status by one clock so that it leaves a flop.
  assign next_irq  = |(irq_stat & irq_en);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= `CTAF_RST_IRQ;
      irq_en   <= `CTAF_RST_IRQ;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      irq_en   <= next_en;
      irq      <= next_irq;
    end
  end

  // Read mux; every unlisted bit reads as zero.
  logic [31:0] rd_abort_done_flags;
  logic [31:0] rd_pick;
  logic [31:0] rd_filter;
  logic [31:0] rd_txflag;
  logic [31:0] rd_abreq;
  logic [31:0] rd_stat;
  logic [31:0] rd_en;
  logic        rd_mapped;

  assign rd_abort_done_flags  = {29'h0, abort_done_flags};
  assign rd_pick   = {29'h0, pick_low};
  assign rd_filter = {26'h0, mode, 1'h0, filter_match_field};
  assign rd_txflag = {29'h0, tx_buffer_empty_flags};
  assign rd_abreq  = {29'h0, abort_request_bits};
  assign rd_stat   = {28'h0, irq_stat};
  assign rd_en     = {28'h0, irq_en};
  assign rd_mapped = (rd_addr == `CTAF_OFS_ABORT_DONE)
                   | (rd_addr == `CTAF_OFS_PICK)
                   | (rd_addr == `CTAF_OFS_FILTER)
                   | (rd_addr == `CTAF_OFS_TX_FLAG)
                   | (rd_addr == `CTAF_OFS_ABORT_REQ)
                   | (rd_addr == `CTAF_OFS_IRQ_STAT)
                   | (rd_addr == `CTAF_OFS_IRQ_EN)
                   | (rd_addr == `CTAF_OFS_IRQ_CLR);
  // The clear register is write-only and reads as zero, but unlike a gap it answers without an error.
  assign rd_err    = ~rd_mapped;
  assign rd_data   =
      (rd_addr == `CTAF_OFS_ABORT_DONE) ? rd_abort_done_flags  :
      (rd_addr == `CTAF_OFS_PICK)       ? rd_pick   :
      (rd_addr == `CTAF_OFS_FILTER)     ? rd_filter :
      (rd_addr == `CTAF_OFS_TX_FLAG)    ? rd_txflag :
      (rd_addr == `CTAF_OFS_ABORT_REQ)  ? rd_abreq  :
      (rd_addr == `CTAF_OFS_IRQ_STAT)   ? rd_stat   :
      (rd_addr == `CTAF_OFS_IRQ_EN)     ? rd_en     :
      32'h00000000;
endmodule
`default_nettype wire

/* dv/ctaf_top_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module ctaf_top_sva (
  // Clock and mode
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       init_request,
  input wire logic       init_acknowledge,
  // Transmit side
  input wire logic [2:0] tx_sent,
  input wire logic [2:0] tx_active,
  input wire logic [2:0] tx_buffer_empty_flags,
  input wire logic [2:0] abort_request_bits,
  input wire logic [2:0] tx_window_sel,
  input wire logic       tx_window_open,
  // Receive side
  input wire logic       rx_shift,
  input wire logic [1:0] filter_mode,
  input wire logic [7:0] filter_enables,
  input wire logic       rx_fg_load
);
  wire logic init_on;
  logic [1:0] up;
  assign init_on = init_request && init_acknowledge;
  // Internal reset outlives resetn by two edges, so some checks wait.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_init_window;
    init_on ##1 init_on |=> tx_window_sel == 3'h0 && !tx_window_open;
  endproperty
  a_init_window: assert property (p_init_window)
    else $error("window left open in init");
  property p_req_flag;
    (abort_request_bits & tx_buffer_empty_flags) == 3'h0;
  endproperty
  a_req_flag: assert property (p_req_flag)
    else $error("abort request kept on empty buffer");
  property p_sent;
    |tx_sent |=> (tx_buffer_empty_flags & $past(tx_sent)) == $past(tx_sent);
  endproperty
  a_sent: assert property (p_sent)
    else $error("sent buffer not flagged empty");
  property p_rise;
    !$past(init_on) |-> (tx_buffer_empty_flags & ~$past(tx_buffer_empty_flags)
      & ~($past(tx_sent) | ($past(abort_request_bits) & ~$past(tx_active))))
      == 3'h0;
  endproperty
  a_rise: assert property (p_rise)
    else $error("empty flag set without cause");
  property p_open;
    tx_window_open |-> tx_window_sel != 3'h0
      && (tx_window_sel & $past(tx_buffer_empty_flags)) != 3'h0;
  endproperty
  a_open: assert property (p_open)
    else $error("window open on busy or no buffer");
  property p_fg_load;
    up == 2'h3 |-> rx_fg_load == ($past(rx_shift) && filter_mode != 2'h3);
  endproperty
  a_fg_load: assert property (p_fg_load)
    else $error("foreground load wrong");
  property p_enables;
    up == 2'h3 |-> filter_enables ==
      (filter_mode == 2'h0 ? 8'h03 : filter_mode == 2'h1 ? 8'h0F :
       filter_mode == 2'h2 ? 8'hFF : 8'h00);
  endproperty
  a_enables: assert property (p_enables)
    else $error("filter enables do not match mode");
  property p_mode;
    !$stable(filter_mode) |-> $past(init_on, 2);
  endproperty
  a_mode: assert property (p_mode)
    else $error("filter mode changed outside init");
endmodule
bind ctaf_top ctaf_top_sva u_sva (.sys_clk, .resetn, .init_request,
  .init_acknowledge, .tx_sent, .tx_active, .tx_buffer_empty_flags,
  .abort_request_bits, .tx_window_sel, .tx_window_open, .rx_shift,
  .filter_mode, .filter_enables, .rx_fg_load);
`default_nettype wire

/* dv/ctaf_can_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ctaf_can_model (
  // Clock
  input  wire logic       sys_clk,
  // Transmit engine
  output logic      [2:0] tx_sent,
  output logic      [2:0] tx_active,
  // Receive path
  output logic            rx_shift,
  output logic      [2:0] rx_hit_in
);
  initial begin
    tx_sent = 3'h0;
    tx_active = 3'h0;
    rx_shift = 1'b0;
    rx_hit_in = 3'h0;
  end
  task automatic start(input logic [2:0] b);
    @(posedge sys_clk);
    tx_active <= b;
  endtask
  task automatic send(input logic [2:0] b);
    @(posedge sys_clk);
    tx_sent <= b;
    @(posedge sys_clk);
    tx_sent <= 3'h0;
  endtask
  // Hit lines mean nothing outside a load, so they are turned over then.
  task automatic rx(input logic [2:0] h);
    @(posedge sys_clk);
    rx_shift <= 1'b1;
    rx_hit_in <= h;
    @(posedge sys_clk);
    rx_shift <= 1'b0;
    rx_hit_in <= ~h;
  endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ctaf_map.svh"
module testbench;
  logic        sys_clk, resetn, init_request, init_acknowledge, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, filter_enables;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, tx_window_open, rx_shift;
  logic        rx_fg_load;
  logic [1:0]  s_axi_bresp, s_axi_rresp, filter_mode;
  logic [2:0]  tx_sent, tx_active, tx_buffer_empty_flags, abort_request_bits;
  logic [2:0]  tx_window_sel, rx_hit_in;
  int          failures, total_checks, cycles;
  ctaf_top u_dut (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .init_request, .init_acknowledge, .tx_sent, .tx_active,
    .tx_buffer_empty_flags, .abort_request_bits, .tx_window_sel,
    .tx_window_open, .rx_shift, .rx_hit_in, .filter_mode, .filter_enables,
    .rx_fg_load, .irq);
  ctaf_can_model u_can (.sys_clk, .tx_sent, .tx_active, .rx_shift,
    .rx_hit_in);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = `CTAF_RESP_OKAY);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge sys_clk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = `CTAF_RESP_OKAY);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  task automatic init_mode(input logic v);
    @(posedge sys_clk);
    init_request <= v;
    init_acknowledge <= v;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd(8'(i * 4), i == 3 ? 32'h7 : 32'h0);
    rd(8'h20, 32'h0, `CTAF_RESP_SLVERR);
    wr(8'h20, 32'hFF, `CTAF_RESP_SLVERR);
    wr(`CTAF_OFS_TX_FLAG, 32'hFFFFFF00);
    rd(`CTAF_OFS_TX_FLAG, 32'h7);
    s_axi_wstrb <= 4'hE;
    wr(`CTAF_OFS_TX_FLAG, 32'h7);
    s_axi_wstrb <= 4'hF;
    rd(`CTAF_OFS_TX_FLAG, 32'h7);
    $display("test reset done");
  endtask
  task automatic t_pick();
    logic [2:0] wv [4] = '{3'h6, 3'h3, 3'h4, 3'h0};
    logic [2:0] ev [4] = '{3'h2, 3'h1, 3'h4, 3'h0};
    for (int i = 0; i < 4; i++) begin
      wr(`CTAF_OFS_PICK, {29'h0, wv[i]});
      rd(`CTAF_OFS_PICK, {29'h0, ev[i]});
      chk("window_sel", {29'h0, ev[i]}, {29'h0, tx_window_sel});
      chk("window_open", {31'h0, |ev[i]}, {31'h0, tx_window_open});
    end
    $display("test pick done");
  endtask
  task automatic t_abort();
    wr(`CTAF_OFS_IRQ_EN, 32'h1);
    wr(`CTAF_OFS_TX_FLAG, 32'h1);
    u_can.start(3'h1);
    wr(`CTAF_OFS_PICK, 32'h1);
    wr(`CTAF_OFS_ABORT_REQ, 32'h1);
    rd(`CTAF_OFS_ABORT_DONE, 32'h0);
    chk("window_open", 32'h0, {31'h0, tx_window_open});
    chk("abort_req", 32'h1, {29'h0, abort_request_bits});
    u_can.start(3'h0);
    rd(`CTAF_OFS_ABORT_DONE, 32'h1);
    chk("empty", 32'h7, {29'h0, tx_buffer_empty_flags});
    chk("abort_req", 32'h0, {29'h0, abort_request_bits});
    chk("irq", 32'h1, {31'h0, irq});
    wr(`CTAF_OFS_ABORT_DONE, 32'h0);
    rd(`CTAF_OFS_ABORT_DONE, 32'h1);
    rd(`CTAF_OFS_IRQ_STAT, 32'h1);
    wr(`CTAF_OFS_IRQ_CLR, 32'hF);
    rd(`CTAF_OFS_IRQ_STAT, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`CTAF_OFS_TX_FLAG, 32'h1);
    rd(`CTAF_OFS_ABORT_DONE, 32'h0);
    wr(`CTAF_OFS_IRQ_EN, 32'h0);
    u_can.send(3'h1);
    rd(`CTAF_OFS_ABORT_DONE, 32'h0);
    rd(`CTAF_OFS_IRQ_STAT, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test abort done");
  endtask
  task automatic t_filter();
    logic [7:0] lut [4] = '{8'h03, 8'h0F, 8'hFF, 8'h00};
    wr(`CTAF_OFS_TX_FLAG, 32'h2);
    wr(`CTAF_OFS_ABORT_REQ, 32'h2);
    rd(`CTAF_OFS_ABORT_DONE, 32'h2);
    wr(`CTAF_OFS_FILTER, 32'h10);
    rd(`CTAF_OFS_FILTER, 32'h0);
    init_mode(1'b1);
    wr(`CTAF_OFS_PICK, 32'h1);
    rd(`CTAF_OFS_PICK, 32'h0);
    rd(`CTAF_OFS_ABORT_DONE, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(`CTAF_OFS_FILTER, {26'h0, 2'(m), 4'h7});
      rd(`CTAF_OFS_FILTER, {26'h0, 2'(m), 4'h0});
      chk("enables", {24'h0, lut[m]}, {24'h0, filter_enables});
    end
    init_mode(1'b0);
    u_can.rx(3'h5);
    rd(`CTAF_OFS_FILTER, 32'h30);
    rd(`CTAF_OFS_IRQ_STAT, 32'h3);
    init_mode(1'b1);
    wr(`CTAF_OFS_FILTER, 32'h0);
    init_mode(1'b0);
    for (int h = 7; h >= 0; h--) begin
      u_can.rx(3'(h));
      rd(`CTAF_OFS_FILTER, 32'(h));
    end
    rd(`CTAF_OFS_IRQ_STAT, 32'hB);
    $display("test filter done");
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    failures = 0;
    total_checks = 0;
    cycles = 0;
    resetn = 1'b0;
    init_request = 1'b0;
    init_acknowledge = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_pick();
    t_abort();
    t_filter();
    final_report();
  end
endmodule
`default_nettype wire
